// ===== rtl/sscs_pkg.sv
package sscs_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    localparam logic [4:0] ADDR_DONE_CNT = 5'h07;
    localparam int ADDR_POS = 0;
    localparam int ACCESS_POS = 7;
    localparam int DATA_POS = 8;

    // ----------------------------------------------------------------
    // Address ranges
    // ----------------------------------------------------------------
    localparam logic [6:0] CTRL_FIRST = 7'h00;
    localparam logic [6:0] CTRL_LAST = 7'h1E;
    localparam int CTRL_NUM = 31;
    localparam logic [6:0] STAT_FIRST = 7'h40;
    localparam logic [6:0] STAT_LAST = 7'h7E;

    // ----------------------------------------------------------------
    // Clearable status registers (array index order)
    // ----------------------------------------------------------------
    localparam int STAT_NUM = 10;
    localparam logic [6:0] SUPPLY_STATUS_SECONDARY = 7'h40;
    localparam logic [6:0] SUPPLY_STATUS_PRIMARY = 7'h41;
    localparam logic [6:0] THERMAL_STATUS = 7'h42;
    localparam logic [6:0] DEVICE_STATUS = 7'h43;
    localparam logic [6:0] BUS_FAILURE_STATUS = 7'h44;
    localparam logic [6:0] BUS_FAILURE_STATUS_B = 7'h45;
    localparam logic [6:0] WAKE_SOURCE_STATUS = 7'h46;
    localparam logic [6:0] WAKE_SOURCE_STATUS_B = 7'h47;
    localparam logic [6:0] SWITCH_OVERLOAD_STATUS = 7'h54;
    localparam logic [6:0] SWITCH_OPEN_LOAD_STATUS = 7'h55;
    localparam logic [STAT_NUM-1:0][6:0] STAT_ADDR = {
        SWITCH_OPEN_LOAD_STATUS, SWITCH_OVERLOAD_STATUS, WAKE_SOURCE_STATUS_B,
        WAKE_SOURCE_STATUS, BUS_FAILURE_STATUS_B, BUS_FAILURE_STATUS, DEVICE_STATUS,
        THERMAL_STATUS, SUPPLY_STATUS_PRIMARY, SUPPLY_STATUS_SECONDARY};

    // Read-only status registers, never cleared
    localparam logic [6:0] WAKE_PIN_LEVEL_STATUS = 7'h48;
    localparam logic [6:0] SELECTIVE_WAKE_STATUS = 7'h4C;
    localparam logic [6:0] FAMILY_PRODUCT_IDENT = 7'h7E;
    // Arbitrary identification value
    localparam logic [7:0] IDENT_VALUE = 8'h5A;

    // ----------------------------------------------------------------
    // Control fields touched by hardware
    // ----------------------------------------------------------------
    localparam logic [6:0] CTRL_MODE = 7'h01;
    localparam int MODE_POS = 0;
    localparam logic [6:0] CTRL_BUS = 7'h03;
    localparam int CAN_POS = 0;
    localparam int LIN_POS = 2;
    localparam logic [1:0] BUS_OFF = 2'h0;
    localparam logic [1:0] BUS_WAKE = 2'h1;
    localparam logic [6:0] CTRL_SUPPLY = 7'h05;
    localparam int SUPA_POS = 0;
    localparam logic [6:0] CTRL_SWITCH = 7'h14;

    localparam logic [7:0] REG_RST = 8'h00;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SSCS_NORMAL, SSCS_STOP, SSCS_SLEEP, SSCS_RESTART} sscs_mode_t;
    typedef enum logic {SSCS_IDLE, SSCS_FRAME} sscs_fsm_t;

    typedef struct packed {
        logic chg;
        sscs_mode_t mode;
    } sscs_mode_ev_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic serial_in_pin;
    } sscs_pins_t;

endpackage

// ===== rtl/sscs_spi.sv
`timescale 1ns/10ps
module sscs_spi (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire sscs_pkg::sscs_pins_t spi_pins_in,
    input wire logic reset_output_pin_n_in,
    input wire sscs_pkg::sscs_mode_ev_t mode_event_in,
    input wire logic [sscs_pkg::STAT_NUM-1:0][7:0] status_event_in,
    input wire logic [7:0] wake_pin_level_in,
    input wire logic [7:0] selective_wake_status_in,
    input wire logic [7:0] switch_fault_in,
    input wire logic fail_trigger_in,
    input wire logic fail_clear_in,
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe_out,
    output logic [7:0] status_summary_out,
    output logic [1:0] mode_config_out,
    output logic [7:0] switch_config_out,
    output logic [7:0] bus_config_out,
    output logic [7:0] supply_config_out,
    output logic fail_output_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        sscs_pkg::sscs_fsm_t fsm;
        sscs_pkg::sscs_pins_t s1;
        sscs_pkg::sscs_pins_t s2;
        sscs_pkg::sscs_pins_t s3;
        logic [4:0] cnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic serial_out_pin;
        logic oe;
        logic err;
        logic bad;
        logic ro_seen;
        sscs_pkg::sscs_mode_t mode;
        logic [sscs_pkg::CTRL_NUM-1:0][7:0] ctrl;
        logic [sscs_pkg::STAT_NUM-1:0][7:0] stat;
        logic [7:0] summary;
        logic fail;
    } sscs_state_t;

    sscs_state_t st_q;
    sscs_state_t st_d;

    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic ro_low;
    logic frame_bad;
    logic frame_good;
    logic do_exec;
    logic [6:0] ex_addr;

    assign cs_fall = st_q.s3.cs_n & ~st_q.s2.cs_n;
    assign cs_rise = ~st_q.s3.cs_n & st_q.s2.cs_n;
    assign sck_rise = ~st_q.s3.sclk & st_q.s2.sclk & ~st_q.s2.cs_n;
    assign sck_fall = st_q.s3.sclk & ~st_q.s2.sclk & ~st_q.s2.cs_n;
    assign ro_low = ~reset_output_pin_n_in;
    assign ex_addr = st_q.rx[sscs_pkg::ADDR_POS +: 7];

    // Frame is bad on wrong count, clock high at a select edge or reset output low
    assign frame_bad = ((st_q.cnt != 5'h00) && (st_q.cnt != sscs_pkg::FRAME_LEN))
        || st_q.bad || st_q.s2.sclk || st_q.ro_seen || ro_low;
    assign frame_good = (st_q.cnt == sscs_pkg::FRAME_LEN) && !frame_bad;
    assign do_exec = (st_q.fsm == sscs_pkg::SSCS_FRAME) && cs_rise && frame_good
        && (st_q.mode != sscs_pkg::SSCS_RESTART);

    // ----------------------------------------------------------------
    // Register read and status index lookup
    // ----------------------------------------------------------------
    function automatic logic [7:0] read_byte(input sscs_state_t s, input logic [6:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a <= sscs_pkg::CTRL_LAST)
        begin
            r = s.ctrl[a[4:0]];
        end
        else if (a == sscs_pkg::WAKE_PIN_LEVEL_STATUS)
        begin
            r = wake_pin_level_in;
        end
        else if (a == sscs_pkg::SELECTIVE_WAKE_STATUS)
        begin
            r = selective_wake_status_in;
        end
        else if (a == sscs_pkg::FAMILY_PRODUCT_IDENT)
        begin
            r = sscs_pkg::IDENT_VALUE;
        end
        else
        begin
            for (int i = 0; i < sscs_pkg::STAT_NUM; i++)
            begin
                if (a == sscs_pkg::STAT_ADDR[i])
                begin
                    r = s.stat[i];
                end
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = spi_pins_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;

        case (st_q.fsm)
            sscs_pkg::SSCS_IDLE:
            begin
                st_d.oe = 1'b0;
                st_d.serial_out_pin = 1'b1;
                if (cs_fall)
                begin
                    st_d.fsm = sscs_pkg::SSCS_FRAME;
                    st_d.cnt = 5'h00;
                    st_d.bad = st_q.s3.sclk;
                    st_d.ro_seen = ro_low;
                    st_d.oe = 1'b1;
                    st_d.serial_out_pin = st_q.err;
                    st_d.tx = {8'h00, st_q.summary};
                end
            end
            sscs_pkg::SSCS_FRAME:
            begin
                if (ro_low)
                begin
                    st_d.ro_seen = 1'b1;
                end
                if (cs_rise)
                begin
                    st_d.fsm = sscs_pkg::SSCS_IDLE;
                    st_d.oe = 1'b0;
                    st_d.serial_out_pin = 1'b1;
                    st_d.err = frame_bad;
                end
                else
                begin
                    if (sck_fall)
                    begin
                        st_d.rx = {st_q.s2.serial_in_pin, st_q.rx[15:1]};
                        if (st_q.cnt != sscs_pkg::CNT_MAX)
                        begin
                            st_d.cnt = st_q.cnt + 5'h01;
                        end
                        if (st_q.cnt == sscs_pkg::ADDR_DONE_CNT)
                        begin
                            st_d.tx[7:0] = read_byte(st_q, st_q.rx[15:9]);
                        end
                    end
                    if (sck_rise)
                    begin
                        st_d.serial_out_pin = st_q.tx[0];
                        st_d.tx = {1'b0, st_q.tx[15:1]};
                    end
                end
            end
            default:
            begin
                st_d.fsm = sscs_pkg::SSCS_IDLE;
            end
        endcase

        if (ro_low)
        begin
            st_d.oe = 1'b1;
            st_d.serial_out_pin = 1'b1;
        end

        // Executed at select rise; new control value visible from next frame
        if (do_exec && st_q.rx[sscs_pkg::ACCESS_POS] && (ex_addr <= sscs_pkg::CTRL_LAST))
        begin
            st_d.ctrl[ex_addr[4:0]] = st_q.rx[sscs_pkg::DATA_POS +: 8];
        end
        for (int i = 0; i < sscs_pkg::STAT_NUM; i++)
        begin
            // Clear only listed registers; events in the same cycle win
            if (do_exec && st_q.rx[sscs_pkg::ACCESS_POS] && (ex_addr == sscs_pkg::STAT_ADDR[i]))
            begin
                st_d.stat[i] = sscs_pkg::REG_RST;
            end
            st_d.stat[i] = st_d.stat[i] | status_event_in[i];
        end

        // Automatic configuration updates on mode change
        if (mode_event_in.chg)
        begin
            st_d.mode = mode_event_in.mode;
            st_d.ctrl[sscs_pkg::CTRL_MODE][sscs_pkg::MODE_POS +: 2] = mode_event_in.mode;
            if (mode_event_in.mode == sscs_pkg::SSCS_SLEEP)
            begin
                if ((st_q.ctrl[sscs_pkg::CTRL_BUS][sscs_pkg::CAN_POS +: 2] != sscs_pkg::BUS_OFF)
                    && (st_q.ctrl[sscs_pkg::CTRL_BUS][sscs_pkg::CAN_POS +: 2]
                    != sscs_pkg::BUS_WAKE))
                begin
                    st_d.ctrl[sscs_pkg::CTRL_BUS][sscs_pkg::CAN_POS +: 2] = sscs_pkg::BUS_WAKE;
                end
                if ((st_q.ctrl[sscs_pkg::CTRL_BUS][sscs_pkg::LIN_POS +: 2] != sscs_pkg::BUS_OFF)
                    && (st_q.ctrl[sscs_pkg::CTRL_BUS][sscs_pkg::LIN_POS +: 2]
                    != sscs_pkg::BUS_WAKE))
                begin
                    st_d.ctrl[sscs_pkg::CTRL_BUS][sscs_pkg::LIN_POS +: 2] = sscs_pkg::BUS_WAKE;
                end
            end
            if (mode_event_in.mode == sscs_pkg::SSCS_RESTART)
            begin
                st_d.ctrl[sscs_pkg::CTRL_SWITCH] = sscs_pkg::REG_RST;
                st_d.ctrl[sscs_pkg::CTRL_SUPPLY][sscs_pkg::SUPA_POS] = 1'b0;
            end
        end

        // Faulted switch turns off; no wake is raised
        st_d.ctrl[sscs_pkg::CTRL_SWITCH] = st_d.ctrl[sscs_pkg::CTRL_SWITCH] & ~switch_fault_in;

        // Fail output stays active across low-power and restart entries
        if (fail_clear_in && (st_q.mode == sscs_pkg::SSCS_NORMAL))
        begin
            st_d.fail = 1'b0;
        end
        if (fail_trigger_in)
        begin
            st_d.fail = 1'b1;
        end

        // Summary field
        st_d.summary[0] = |st_q.stat[1];
        st_d.summary[1] = |st_q.stat[2];
        st_d.summary[2] = |st_q.stat[3];
        st_d.summary[3] = |st_q.stat[4] | |st_q.stat[5];
        st_d.summary[4] = |st_q.stat[6] | |st_q.stat[7];
        st_d.summary[5] = |st_q.stat[0];
        st_d.summary[6] = |st_q.stat[8];
        st_d.summary[7] = |st_q.stat[9];
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_q <= '0;
            st_q.s1 <= 3'h7;
            st_q.s2 <= 3'h7;
            st_q.s3 <= 3'h7;
            st_q.serial_out_pin <= 1'b1;
            st_q.fsm <= sscs_pkg::SSCS_IDLE;
            st_q.mode <= sscs_pkg::SSCS_NORMAL;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign serial_out_pin_out = st_q.serial_out_pin;
    assign serial_out_pin_oe_out = st_q.oe;
    assign status_summary_out = st_q.summary;
    assign mode_config_out = st_q.ctrl[sscs_pkg::CTRL_MODE][sscs_pkg::MODE_POS +: 2];
    assign switch_config_out = st_q.ctrl[sscs_pkg::CTRL_SWITCH];
    assign bus_config_out = st_q.ctrl[sscs_pkg::CTRL_BUS];
    assign supply_config_out = st_q.ctrl[sscs_pkg::CTRL_SUPPLY];
    assign fail_output_out = st_q.fail;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    AST_RO_SDO_HIGH: assert property (ro_low |=> serial_out_pin_out && serial_out_pin_oe_out)
        else $error("serial out not high while reset output low");
    AST_RO_FRAME_ERR: assert property (cs_rise && (st_q.fsm == sscs_pkg::SSCS_FRAME)
        && st_q.ro_seen |=> st_q.err)
        else $error("frame during reset output low not flagged");
    AST_ERR_EARLY: assert property (cs_fall && (st_q.fsm == sscs_pkg::SSCS_IDLE) && st_q.err
        && !ro_low |=> serial_out_pin_out && serial_out_pin_oe_out && (st_q.cnt == 5'h00))
        else $error("pending error not shown before first clock");
    AST_COUNT_ERR: assert property (cs_rise && (st_q.fsm == sscs_pkg::SSCS_FRAME)
        && (st_q.cnt != 5'h00) && (st_q.cnt != sscs_pkg::FRAME_LEN) |=> st_q.err)
        else $error("wrong clock count not flagged");
    AST_RESTART_IGNORE: assert property ((st_q.mode == sscs_pkg::SSCS_RESTART)
        && !mode_event_in.chg && (switch_fault_in == 8'h00) |=> $stable(st_q.ctrl))
        else $error("control changed by frame in restart mode");
    AST_SUMMARY_BUS: assert property (##1 status_summary_out[3]
        == ($past(|st_q.stat[4]) || $past(|st_q.stat[5])))
        else $error("bus summary bit wrong");
    AST_SUMMARY_SUPPLY: assert property (##1 status_summary_out[0] == $past(|st_q.stat[1]))
        else $error("primary supply summary bit wrong");
    AST_STICKY: assert property (!do_exec |=> ((st_q.stat[2] & $past(st_q.stat[2]))
        == $past(st_q.stat[2])))
        else $error("status bit dropped without clear");
    AST_MODE_BITS: assert property (mode_event_in.chg |=> mode_config_out
        == $past(mode_event_in.mode))
        else $error("mode bits do not follow entered mode");
    AST_RESTART_CLEAR: assert property (mode_event_in.chg
        && (mode_event_in.mode == sscs_pkg::SSCS_RESTART) |=> (switch_config_out == 8'h00)
        && !supply_config_out[sscs_pkg::SUPA_POS])
        else $error("restart did not clear switch config");
    AST_WRITE: assert property (do_exec && st_q.rx[7] && (ex_addr == sscs_pkg::CTRL_SUPPLY)
        && !mode_event_in.chg |=> supply_config_out == $past(st_q.rx[15:8]))
        else $error("control write not applied");
    AST_IDLE_RELEASE: assert property ((st_q.fsm == sscs_pkg::SSCS_IDLE) && !cs_fall && !ro_low
        |=> !serial_out_pin_oe_out)
        else $error("serial out not released while deselected");
    AST_SLEEP_BUS: assert property (mode_event_in.chg
        && (mode_event_in.mode == sscs_pkg::SSCS_SLEEP)
        && (st_q.ctrl[sscs_pkg::CTRL_BUS][sscs_pkg::CAN_POS +: 2] == 2'h3)
        |=> (bus_config_out[sscs_pkg::CAN_POS +: 2] == sscs_pkg::BUS_WAKE))
        else $error("sleep entry left bus control active");
    AST_STOP_BUS: assert property (mode_event_in.chg && !do_exec
        && (mode_event_in.mode == sscs_pkg::SSCS_STOP) |=> $stable(bus_config_out))
        else $error("stop entry changed bus control");
    AST_FAIL_HOLD: assert property (st_q.fail && (st_q.mode != sscs_pkg::SSCS_NORMAL)
        |=> fail_output_out)
        else $error("fail output dropped outside normal mode");
    AST_FAULT_OFF: assert property ((switch_fault_in != 8'h00)
        |=> ((switch_config_out & $past(switch_fault_in)) == 8'h00))
        else $error("faulted switch not turned off");
    AST_CLEAR: assert property (do_exec && st_q.rx[sscs_pkg::ACCESS_POS]
        && (ex_addr == sscs_pkg::THERMAL_STATUS) && (status_event_in[2] == 8'h00)
        |=> (st_q.stat[2] == 8'h00))
        else $error("status clear not applied");
    AST_SUMMARY_WAKE: assert property (##1 status_summary_out[4]
        == ($past(|st_q.stat[6]) || $past(|st_q.stat[7])))
        else $error("wake summary bit wrong");
    AST_ERR_CLEAN: assert property (cs_rise && (st_q.fsm == sscs_pkg::SSCS_FRAME)
        && !frame_bad |=> !st_q.err)
        else $error("error flag kept after clean frame");

    COV_GOOD_FRAME: cover property (do_exec);
    COV_POLL: cover property (cs_rise && (st_q.cnt == 5'h00) && st_q.err);
    COV_RO_FRAME: cover property (cs_rise && st_q.ro_seen);
    COV_SLEEP: cover property (mode_event_in.chg && (mode_event_in.mode == sscs_pkg::SSCS_SLEEP));
    COV_RESTART_FRAME: cover property (cs_rise && (st_q.mode == sscs_pkg::SSCS_RESTART));

endmodule // sscs_spi

// ===== sim/sscs_host.sv
`timescale 1ns/10ps
module sscs_host (
    input wire logic clock_in,
    input wire logic sdo_in,
    input wire logic oe_in,
    output sscs_pkg::sscs_pins_t pins_out
);
    // ----
    // Data line as seen by the host
    // ----
    logic last_q = 1'b0;
    logic line;
    // A released line shows the inverse of the last level
    assign line = oe_in ? sdo_in : ~last_q;
    always @(posedge clock_in)
    begin
        last_q <= line;
    end
    initial pins_out = '{cs_n: 1'b1, sclk: 1'b0, serial_in_pin: 1'b0};

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    // ----
    // One frame, nclk clocks, bit 0 first, 160 ns link period
    // ----
    task automatic xfer(input logic [15:0] tx, input int nclk, output logic [7:0] err,
                        output logic [15:0] rx);
        rx = 16'h0000;
        pins_out.cs_n = 1'b0;
        wait_clk(8);
        err = {7'h00, line};
        for (int i = 0; i < nclk; i++)
        begin
            pins_out.serial_in_pin = tx[i];
            pins_out.sclk = 1'b1;
            wait_clk(4);
            rx[i] = line;
            pins_out.sclk = 1'b0;
            wait_clk(4);
        end
        pins_out.cs_n = 1'b1;
        pins_out.serial_in_pin = ~pins_out.serial_in_pin;
        wait_clk(8);
    endtask
endmodule // sscs_host

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    sscs_pkg::sscs_pins_t pins;
    logic ro_n = 1'b1;
    sscs_pkg::sscs_mode_ev_t mev = '0;
    logic [sscs_pkg::STAT_NUM-1:0][7:0] sev = '0;
    logic [7:0] wk_lvl = 8'h3C;
    logic [7:0] swk = 8'hC3;
    logic [7:0] fault = 8'h00;
    logic f_trig = 1'b0;
    logic f_clr = 1'b0;
    logic serial_out_pin, oe, fail;
    logic [7:0] summ, sw_cfg, bus_cfg, sup_cfg, err;
    logic [1:0] mode_cfg;
    logic [15:0] rx;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    localparam int SBIT [10] = '{5, 0, 1, 2, 3, 3, 4, 4, 6, 7};

    always #10 clock_in = ~clock_in;

    sscs_spi dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in), .spi_pins_in(pins),
        .reset_output_pin_n_in(ro_n), .mode_event_in(mev), .status_event_in(sev),
        .wake_pin_level_in(wk_lvl), .selective_wake_status_in(swk), .switch_fault_in(fault),
        .fail_trigger_in(f_trig), .fail_clear_in(f_clr), .serial_out_pin_out(serial_out_pin),
        .serial_out_pin_oe_out(oe), .status_summary_out(summ), .mode_config_out(mode_cfg),
        .switch_config_out(sw_cfg), .bus_config_out(bus_cfg), .supply_config_out(sup_cfg),
        .fail_output_out(fail));
    sscs_host host_u (.clock_in(clock_in), .sdo_in(serial_out_pin), .oe_in(oe), .pins_out(pins));

    // ----
    // Helpers
    // ----
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic frame(input logic [6:0] a, input logic acc, input logic [7:0] d);
        host_u.xfer({d, acc, a}, 16, err, rx);
    endtask
    task automatic poll();
        host_u.xfer(16'h0000, 0, err, rx);
    endtask
    task automatic mode(input sscs_pkg::sscs_mode_t m);
        mev = '{chg: 1'b1, mode: m};
        tick(1);
        mev.chg = 1'b0;
        tick(2);
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        chk("sdo", 8'h01, {7'h00, serial_out_pin});
        chk("oe", 8'h00, {7'h00, oe});
        chk("summary", 8'h00, summ);
        chk("mode", 8'h00, {6'h00, mode_cfg});
        chk("switch", 8'h00, sw_cfg);
        chk("fail", 8'h00, {7'h00, fail});
    endtask
    task automatic t_ctrl();
        frame(sscs_pkg::CTRL_SWITCH, 1'b1, 8'hA5);
        chk("old byte", 8'h00, rx[15:8]);
        chk("switch", 8'hA5, sw_cfg);
        frame(sscs_pkg::CTRL_SWITCH, 1'b0, 8'h00);
        chk("new byte", 8'hA5, rx[15:8]);
        frame(sscs_pkg::CTRL_LAST, 1'b1, 8'h3C);
        frame(sscs_pkg::CTRL_LAST, 1'b0, 8'hFF);
        frame(sscs_pkg::CTRL_LAST, 1'b0, 8'h00);
        chk("last ctrl", 8'h3C, rx[15:8]);
        frame(7'h1F, 1'b1, 8'hFF);
        frame(7'h1F, 1'b0, 8'h00);
        chk("unmapped", 8'h00, rx[15:8]);
    endtask
    task automatic t_status();
        logic [6:0] a;
        for (int i = 0; i < sscs_pkg::STAT_NUM; i++)
        begin
            a = sscs_pkg::STAT_ADDR[i];
            sev[i] = 8'h81;
            tick(1);
            sev[i] = 8'h00;
            tick(2);
            chk("summary", 8'h01 << SBIT[i], summ);
            frame(a, 1'b0, 8'h00);
            chk("status", 8'h81, rx[15:8]);
            chk("resp summary", 8'h01 << SBIT[i], rx[7:0]);
            frame(a, 1'b1, 8'h00);
            chk("sticky", 8'h81, rx[15:8]);
            tick(2);
            chk("summary clr", 8'h00, summ);
            frame(a, 1'b0, 8'h00);
            chk("cleared", 8'h00, rx[15:8]);
        end
    endtask
    task automatic t_fixed();
        logic [6:0] a [3];
        logic [7:0] v [3];
        a = '{sscs_pkg::WAKE_PIN_LEVEL_STATUS, sscs_pkg::SELECTIVE_WAKE_STATUS,
              sscs_pkg::FAMILY_PRODUCT_IDENT};
        v = '{wk_lvl, swk, sscs_pkg::IDENT_VALUE};
        for (int i = 0; i < 3; i++)
        begin
            frame(a[i], 1'b1, 8'h00);
            frame(a[i], 1'b0, 8'h00);
            chk("fixed", v[i], rx[15:8]);
            chk("summary", 8'h00, rx[7:0]);
        end
    endtask
    task automatic t_count();
        int n [2];
        n = '{1, 15};
        for (int i = 0; i < 2; i++)
        begin
            host_u.xfer({8'h11, 1'b1, sscs_pkg::CTRL_SWITCH}, n[i], err, rx);
            chk("switch", 8'hA5, sw_cfg);
            poll();
            chk("err", 8'h01, err);
            poll();
            chk("err clean", 8'h00, err);
        end
    endtask
    task automatic t_ro();
        ro_n = 1'b0;
        tick(2);
        chk("sdo low ro", 8'h01, {7'h00, serial_out_pin});
        chk("oe low ro", 8'h01, {7'h00, oe});
        frame(sscs_pkg::CTRL_SWITCH, 1'b1, 8'h0F);
        chk("resp low ro", 8'hFF, rx[7:0]);
        ro_n = 1'b1;
        tick(2);
        chk("oe released", 8'h00, {7'h00, oe});
        poll();
        chk("err", 8'h01, err);
        chk("switch", 8'hA5, sw_cfg);
        fork
            frame(sscs_pkg::CTRL_SWITCH, 1'b1, 8'h0F);
            begin
                tick(60);
                ro_n = 1'b0;
            end
        join
        ro_n = 1'b1;
        tick(2);
        poll();
        chk("err", 8'h01, err);
        ro_n = 1'b0;
        // Response of this frame is discarded
        fork
            frame(sscs_pkg::CTRL_SWITCH, 1'b1, 8'h0F);
            begin
                tick(60);
                ro_n = 1'b1;
            end
        join
        poll();
        chk("err", 8'h01, err);
        chk("switch", 8'hA5, sw_cfg);
    endtask
    task automatic t_modes();
        frame(sscs_pkg::CTRL_BUS, 1'b1, 8'h0B);
        f_trig = 1'b1;
        tick(1);
        f_trig = 1'b0;
        mode(sscs_pkg::SSCS_STOP);
        chk("mode", 8'h01, {6'h00, mode_cfg});
        chk("bus stop", 8'h0B, bus_cfg);
        fault = 8'h01;
        tick(2);
        fault = 8'h00;
        chk("switch fault", 8'hA4, sw_cfg);
        f_clr = 1'b1;
        tick(1);
        f_clr = 1'b0;
        tick(1);
        chk("fail", 8'h01, {7'h00, fail});
        mode(sscs_pkg::SSCS_NORMAL);
        mode(sscs_pkg::SSCS_SLEEP);
        chk("mode", 8'h02, {6'h00, mode_cfg});
        chk("bus sleep", 8'h05, bus_cfg);
        chk("switch", 8'hA4, sw_cfg);
        mode(sscs_pkg::SSCS_NORMAL);
        frame(sscs_pkg::CTRL_BUS, 1'b1, 8'h03);
        frame(sscs_pkg::CTRL_SUPPLY, 1'b1, 8'h03);
        mode(sscs_pkg::SSCS_SLEEP);
        chk("bus off", 8'h01, bus_cfg);
        mode(sscs_pkg::SSCS_RESTART);
        chk("mode", 8'h03, {6'h00, mode_cfg});
        chk("switch", 8'h00, sw_cfg);
        chk("supply", 8'h02, sup_cfg);
        chk("fail", 8'h01, {7'h00, fail});
        frame(sscs_pkg::CTRL_SWITCH, 1'b1, 8'hFF);
        poll();
        chk("switch", 8'h00, sw_cfg);
        chk("err", 8'h00, err);
        mode(sscs_pkg::SSCS_NORMAL);
        f_clr = 1'b1;
        tick(1);
        f_clr = 1'b0;
        tick(1);
        chk("fail", 8'h00, {7'h00, fail});
    endtask

    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    initial
    begin
        tick(20);
        reset_n_in = 1'b1;
        tick(4);
        t_reset();
        t_ctrl();
        t_status();
        t_fixed();
        t_count();
        t_ro();
        t_modes();
        report_and_stop();
    end
endmodule // tb_top
